// File: updown_timer_pkg.sv
// constants and types shared by the up/down reload timer
// assumes a 20 MHz pclk and a 32-bit apb slave port
`default_nettype none
package updown_timer_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_offset   = 8'h00;
  localparam logic [7:0] mode_offset   = 8'h04;
  localparam logic [7:0] count_offset  = 8'h08;
  localparam logic [7:0] reload_offset = 8'h0c;
  // timer_control_reg field positions
  localparam int ovf_bit   = 7;
  localparam int ext_bit   = 6;
  localparam int rx_sel_bit = 5;
  localparam int tx_sel_bit = 4;
  localparam int exen_bit  = 3;
  localparam int run_bit   = 2;
  localparam int csel_bit  = 1;
  localparam int cprl_bit  = 0;
  // timer_mode_reg field positions
  localparam int oe_bit    = 1;
  localparam int down_en_bit = 0;
  // reset values
  localparam logic [7:0]  ctrl_reset  = 8'h00;
  localparam logic [1:0]  mode_reset  = 2'h0;
  localparam logic [15:0] count_reset = 16'h0000;
  // counts
  localparam logic [3:0]  presc_last  = 4'hb;      // divide by 12
  localparam logic [15:0] count_max   = 16'hffff;
  localparam logic [15:0] count_zero  = 16'h0000;
  // operating modes
  typedef enum logic [1:0] {
    mode_capture = 2'b00,
    mode_reload  = 2'b01,
    mode_baud    = 2'b10
  } op_mode_t;
endpackage
`default_nettype wire

// File: updown_reload_clockout_timer.sv
// 16-bit up/down auto-reload timer with clock output, apb slave
// assumes pins are asynchronous to pclk; serial port consumes baud_tick
//
// Operation
// - 16-bit count from two cascaded bytes
// - counter_select picks pclk/12 or pin edges
// - count only while run_control set
// - three modes from clock and reload selects
// - down_count_enable lets direction pin steer
// - up overflow at ffff sets flag, reloads; capture mode wraps to 0000
// - down underflow at reload loads ffff
// - external_flag toggles in up/down, no irq
// - clock-out counts at pclk/2, 50% duty
// - clock-out overflow reloads, no interrupt
// - clock-out freq pclk/(4*(65536-reload))
// - generated clock drives count/clockout pin
// - baud and clock-out share reload pair
// - flag set only without serial clocking
// - trigger falling edge captures or reloads
// - serial clocking forces auto-reload
`default_nettype none
module updown_reload_clockout_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_clockout_in,
  output logic             count_clockout_out,
  output logic             count_clockout_oe,
  input  wire logic        direction_trigger_in,
  output logic             irq_request,
  output logic             baud_tick
);

  typedef struct packed {
    logic        dir_meta;
    logic        dir_sync;
    logic        dir_prev;
    logic        cnt_meta;
    logic        cnt_sync;
    logic        cnt_prev;
    logic [3:0]  presc;
    logic        half;
    logic [15:0] count;
    logic [15:0] reload;
    logic        ovf;
    logic        ext;
    logic        rx_sel;
    logic        tx_sel;
    logic        exen;
    logic        run;
    logic        csel;
    logic        cprl;
    logic        oe;
    logic        down_en;
    logic        clk_out;
    logic        irq;
    logic        baud;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // mode from the serial clock selects and capture/reload select
  function automatic updown_timer_pkg::op_mode_t decode_mode(
    input logic rx_sel,
    input logic tx_sel,
    input logic cprl
  );
    if (rx_sel | tx_sel)
      decode_mode = updown_timer_pkg::mode_baud;
    else if (cprl)
      decode_mode = updown_timer_pkg::mode_capture;
    else
      decode_mode = updown_timer_pkg::mode_reload;
  endfunction

  logic                      trig_fall;
  logic                      pin_fall;
  logic                      clkout_mode;
  logic                      serial_clk;
  logic                      updown;
  logic                      count_down;
  logic                      tick;
  logic                      set_ovf;
  logic                      set_ext;
  logic                      tog_ext;
  logic                      setup;
  logic                      access;
  logic                      mapped;
  logic                      wr_ctrl;
  logic                      wr_mode;
  logic                      wr_count;
  logic                      wr_reload;
  logic                      ext_base;
  logic [31:0]               rd_mux;
  logic [15:0]               hw_count;
  logic [15:0]               hw_reload;
  updown_timer_pkg::op_mode_t mode;

  // next-state logic for counter, flags, pins and apb slave
  always_comb begin
    nxt_state = state_ff;
    // two-flop synchronisers plus edge history
    nxt_state.dir_meta = direction_trigger_in;
    nxt_state.dir_sync = state_ff.dir_meta;
    nxt_state.dir_prev = state_ff.dir_sync;
    nxt_state.cnt_meta = count_clockout_in;
    nxt_state.cnt_sync = state_ff.cnt_meta;
    nxt_state.cnt_prev = state_ff.cnt_sync;
    // edges compare the synced flop with its history, never the first flop
    trig_fall = state_ff.dir_prev & ~state_ff.dir_sync;
    pin_fall  = state_ff.cnt_prev & ~state_ff.cnt_sync;

    mode        = decode_mode(state_ff.rx_sel, state_ff.tx_sel, state_ff.cprl);
    serial_clk  = (mode == updown_timer_pkg::mode_baud);
    clkout_mode = state_ff.oe & ~state_ff.csel;
    // direction pin only steers in plain auto-reload mode
    updown      = state_ff.down_en & ~clkout_mode
                  & (mode == updown_timer_pkg::mode_reload);
    count_down  = updown & ~state_ff.dir_sync;

    // prescaler: pclk/12 for timer, pclk/2 for clock-out
    // prescaler free-runs, so run_control does not restart its phase
    nxt_state.half = clkout_mode ? ~state_ff.half : 1'b0;
    if (state_ff.presc == updown_timer_pkg::presc_last)
      nxt_state.presc = 4'h0;
    else
      nxt_state.presc = state_ff.presc + 4'h1;
    if (clkout_mode)
      tick = state_ff.half;
    else if (state_ff.csel)
      tick = pin_fall;
    else
      tick = (state_ff.presc == updown_timer_pkg::presc_last);
    tick = tick & state_ff.run;

    set_ovf   = 1'b0;
    set_ext   = 1'b0;
    tog_ext   = 1'b0;
    hw_count  = state_ff.count;
    hw_reload = state_ff.reload;
    nxt_state.baud = 1'b0;

    // counting with overflow and underflow handling
    if (tick) begin
      if (!count_down) begin
        if (state_ff.count == updown_timer_pkg::count_max) begin
          if (mode == updown_timer_pkg::mode_capture && !clkout_mode)
            hw_count = updown_timer_pkg::count_zero;
          else
            hw_count = state_ff.reload;
          set_ovf = ~serial_clk & ~clkout_mode;
          tog_ext = updown;
          nxt_state.baud = serial_clk;
          if (clkout_mode)
            nxt_state.clk_out = ~state_ff.clk_out;
        end else begin
          hw_count = state_ff.count + 16'h0001;
        end
      end else begin
        if (state_ff.count == state_ff.reload) begin
          hw_count = updown_timer_pkg::count_max;
          set_ovf  = 1'b1;
          tog_ext  = 1'b1;
        end else begin
          hw_count = state_ff.count - 16'h0001;
        end
      end
    end

    // trigger pin falling edge: capture or reload
    if (state_ff.exen && trig_fall && !serial_clk && !updown) begin
      set_ext = 1'b1;
      if (mode == updown_timer_pkg::mode_capture)
        hw_reload = state_ff.count;
      else
        hw_count = state_ff.reload;
    end

    // apb decode: registered answer, one access cycle
    setup  = psel & ~penable;
    access = psel & penable & state_ff.pready;
    mapped = (paddr == updown_timer_pkg::ctrl_offset)
           | (paddr == updown_timer_pkg::mode_offset)
           | (paddr == updown_timer_pkg::count_offset)
           | (paddr == updown_timer_pkg::reload_offset);
    wr_ctrl   = access & pwrite & (paddr == updown_timer_pkg::ctrl_offset);
    wr_mode   = access & pwrite & (paddr == updown_timer_pkg::mode_offset);
    wr_count  = access & pwrite & (paddr == updown_timer_pkg::count_offset);
    wr_reload = access & pwrite & (paddr == updown_timer_pkg::reload_offset);

    rd_mux = 32'h0000_0000;
    case (paddr)
      updown_timer_pkg::ctrl_offset: begin
        rd_mux[updown_timer_pkg::ovf_bit]  = state_ff.ovf;
        rd_mux[updown_timer_pkg::ext_bit]  = state_ff.ext;
        rd_mux[updown_timer_pkg::rx_sel_bit] = state_ff.rx_sel;
        rd_mux[updown_timer_pkg::tx_sel_bit] = state_ff.tx_sel;
        rd_mux[updown_timer_pkg::exen_bit] = state_ff.exen;
        rd_mux[updown_timer_pkg::run_bit]  = state_ff.run;
        rd_mux[updown_timer_pkg::csel_bit] = state_ff.csel;
        rd_mux[updown_timer_pkg::cprl_bit] = state_ff.cprl;
      end
      updown_timer_pkg::mode_offset: begin
        rd_mux[updown_timer_pkg::oe_bit]   = state_ff.oe;
        rd_mux[updown_timer_pkg::down_en_bit] = state_ff.down_en;
      end
      updown_timer_pkg::count_offset: begin
        rd_mux[15:0] = state_ff.count;
      end
      updown_timer_pkg::reload_offset: begin
        rd_mux[15:0] = state_ff.reload;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase

    // error flag is kept through the access edge, then dropped
    nxt_state.pready = setup;
    if (setup) begin
      nxt_state.prdata  = rd_mux;
      nxt_state.pslverr = ~mapped;
    end else if (access) begin
      nxt_state.pslverr = state_ff.pslverr;
    end else begin
      nxt_state.pslverr = 1'b0;
    end

    // control bits written by software
    if (wr_ctrl) begin
      nxt_state.rx_sel = pwdata[updown_timer_pkg::rx_sel_bit];
      nxt_state.tx_sel = pwdata[updown_timer_pkg::tx_sel_bit];
      nxt_state.exen = pwdata[updown_timer_pkg::exen_bit];
      nxt_state.run  = pwdata[updown_timer_pkg::run_bit];
      nxt_state.csel = pwdata[updown_timer_pkg::csel_bit];
      nxt_state.cprl = pwdata[updown_timer_pkg::cprl_bit];
    end
    if (wr_mode) begin
      nxt_state.oe   = pwdata[updown_timer_pkg::oe_bit];
      nxt_state.down_en = pwdata[updown_timer_pkg::down_en_bit];
    end

    // sticky flags: hardware set beats a software clear
    nxt_state.ovf = set_ovf
                  | (wr_ctrl ? pwdata[updown_timer_pkg::ovf_bit] : state_ff.ovf);
    // a toggle beats a clear, so the 17th count bit is never lost
    ext_base = wr_ctrl ? pwdata[updown_timer_pkg::ext_bit] : state_ff.ext;
    nxt_state.ext = tog_ext ? ~state_ff.ext : (set_ext | ext_base);

    // software writes to count or reload take priority
    nxt_state.count  = wr_count  ? pwdata[15:0] : hw_count;
    nxt_state.reload = wr_reload ? pwdata[15:0] : hw_reload;

    // clock output register held low outside clock-out mode
    if (!clkout_mode)
      nxt_state.clk_out = 1'b0;

    // interrupt request: external flag silent in up/down mode
    // level request; apart from the down_en gate on ext, masking belongs to the interrupt controller
    nxt_state.irq = nxt_state.ovf | (nxt_state.ext & ~nxt_state.down_en);
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff         <= '0;
      state_ff.count   <= updown_timer_pkg::count_reset;
      state_ff.reload  <= updown_timer_pkg::count_reset;
      state_ff.ovf     <= updown_timer_pkg::ctrl_reset[updown_timer_pkg::ovf_bit];
      state_ff.ext     <= updown_timer_pkg::ctrl_reset[updown_timer_pkg::ext_bit];
      state_ff.run     <= updown_timer_pkg::ctrl_reset[updown_timer_pkg::run_bit];
      state_ff.oe      <= updown_timer_pkg::mode_reset[updown_timer_pkg::oe_bit];
      state_ff.down_en <= updown_timer_pkg::mode_reset[updown_timer_pkg::down_en_bit];
      state_ff.clk_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops
  assign prdata             = state_ff.prdata;
  assign pready             = state_ff.pready;
  assign pslverr            = state_ff.pslverr;
  assign count_clockout_out = state_ff.clk_out;
  assign count_clockout_oe  = state_ff.oe;
  assign irq_request        = state_ff.irq;
  assign baud_tick          = state_ff.baud;

endmodule // updown_reload_clockout_timer
`default_nettype wire

// File: updown_timer_props.sv
// checker on the timer apb answer and pin outputs
// assumes it is bound into updown_reload_clockout_timer
`default_nettype none
module updown_timer_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        count_clockout_out,
  input wire logic        count_clockout_oe,
  input wire logic        baud_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer, error and data width
  a_ready_setup:
    assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("long ready");
  a_err_map:
    assert property (pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
      else $error("bad slverr");
  a_err_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  a_hi_zero:
    assert property (pready && !pwrite |-> prdata[31:16] == 16'h0) else $error("high bits");
  // pin outputs
  a_oe_follow:
    assert property (pready && pwrite && paddr == 8'h04 |=> count_clockout_oe == $past(pwdata[1]))
      else $error("oe lag");
  a_out_idle:
    assert property (!count_clockout_oe [*3] |-> !count_clockout_out) else $error("stray clock");
  a_out_hold:
    assert property ($changed(count_clockout_out) |=> $stable(count_clockout_out))
      else $error("short half");
  a_baud_gap:
    assert property (baud_tick |=> !baud_tick [*3]) else $error("baud burst");
endmodule // updown_timer_props
bind updown_reload_clockout_timer updown_timer_props updown_timer_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .count_clockout_out(count_clockout_out), .count_clockout_oe(count_clockout_oe),
  .baud_tick(baud_tick));
`default_nettype wire

// File: pin_partner.sv
// far-side pins: count pulses and direction line
// assumes the device owns the count pin while its enable is high
`default_nettype none
module pin_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic oe,
  input  wire logic dev_out,
  input  wire logic dir_up,
  input  wire logic pulse_go,
  output logic      count_pin,
  output logic      dir_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left_ff;
  // one request gives 3 pclk low then 3 high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) left_ff <= 3'h0;
    else if (pulse_go && left_ff == 3'h0) left_ff <= 3'h6;
    else if (left_ff != 3'h0) left_ff <= left_ff - 3'h1;
  end
  // pull-up when idle; device wins while enabled
  assign count_pin = oe ? dev_out : !(left_ff > 3'h3);
  assign dir_pin   = dir_up;
endmodule // pin_partner
`default_nettype wire

// File: updown_reload_clockout_timer_tb.sv
// self-checking bench for the up/down reload timer
// assumes an apb slave that answers within 20 cycles and the pin partner
`default_nettype none
module updown_reload_clockout_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] o_ct = updown_timer_pkg::ctrl_offset;
  localparam logic [7:0] o_md = updown_timer_pkg::mode_offset;
  localparam logic [7:0] o_cn = updown_timer_pkg::count_offset;
  localparam logic [7:0] o_rl = updown_timer_pkg::reload_offset;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        c_in, c_out, c_oe, d_in, irq_request, baud_tick, dir_up, pulse_go;
  int          error_cnt, checked, n, a, b;
  updown_reload_clockout_timer updown_reload_clockout_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_clockout_in(c_in), .count_clockout_out(c_out), .count_clockout_oe(c_oe),
    .direction_trigger_in(d_in), .irq_request(irq_request), .baud_tick(baud_tick));
  pin_partner pin_partner_i (.pclk(pclk), .presetn(presetn), .oe(c_oe), .dev_out(c_out),
    .dir_up(dir_up), .pulse_go(pulse_go), .count_pin(c_in), .dir_pin(d_in));
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      close_out();
    end
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    bound(k, 20);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait for clock-out, irq or baud tick to reach a level
  task automatic wt(input int s, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (((s == 0) ? c_out : (s == 1) ? irq_request : baud_tick) !== v && cnt < 99);
    bound(cnt, 99);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, pulse_go} <= '0;
    dir_up <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then an unmapped word
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rv, 32'h0);
    end
    check(c_out, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(ev, 1'b1);
    check(rv, 32'h0);
    // down counting through the reload point
    dir_up <= 1'b0;
    apb(1'b1, o_md, 32'h1);
    apb(1'b1, o_rl, 32'h0010);
    apb(1'b1, o_cn, 32'h0012);
    apb(1'b1, o_ct, 32'h04);
    repeat (48) @(posedge pclk);
    apb(1'b0, o_cn, 32'h0);
    check(rv[15:8], 8'hff);
    apb(1'b0, o_ct, 32'h0);
    check(rv, 32'hc4);
    apb(1'b1, o_ct, 32'h44);
    @(posedge pclk);
    check(irq_request, 1'b0);
    // plain up counting, direction pin ignored
    apb(1'b1, o_ct, 32'h0);
    apb(1'b1, o_md, 32'h0);
    apb(1'b1, o_rl, 32'hffff1234);
    apb(1'b0, o_rl, 32'h0);
    check(rv, 32'h1234);
    apb(1'b1, o_cn, 32'hfffe);
    apb(1'b1, o_ct, 32'h04);
    wt(1, 1'b1, n);
    apb(1'b0, o_cn, 32'h0);
    check(rv[15:4], 12'h123);
    apb(1'b0, o_ct, 32'h0);
    check(rv, 32'h84);
    // serial clocking with capture selected
    apb(1'b1, o_ct, 32'h0);
    apb(1'b1, o_rl, 32'hffff);
    apb(1'b1, o_cn, 32'hffff);
    apb(1'b1, o_ct, 32'h25);
    wt(2, 1'b1, n);
    wt(2, 1'b0, n);
    wt(2, 1'b1, a);
    check(a + n, 12);
    apb(1'b0, o_cn, 32'h0);
    check(rv, 32'hffff);
    apb(1'b0, o_ct, 32'h0);
    check(rv, 32'h25);
    // pin edge counting, then a trigger reload
    apb(1'b1, o_ct, 32'h0);
    dir_up <= 1'b1;
    apb(1'b1, o_rl, 32'h00ab);
    apb(1'b1, o_cn, 32'h0);
    apb(1'b1, o_ct, 32'h06);
    for (int i = 0; i < 5; i++) begin
      pulse_go <= 1'b1;
      @(posedge pclk);
      pulse_go <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    apb(1'b0, o_cn, 32'h0);
    check(rv, 32'h5);
    apb(1'b1, o_ct, 32'h0e);
    dir_up <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, o_cn, 32'h0);
    check(rv, 32'hab);
    check(irq_request, 1'b1);
    // capture mode: trigger fall copies the count into the reload pair
    apb(1'b1, o_ct, 32'h0f);
    apb(1'b1, o_cn, 32'h0123);
    dir_up <= 1'b1;
    repeat (8) @(posedge pclk);
    dir_up <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, o_rl, 32'h0);
    check(rv, 32'h0123);
    apb(1'b0, o_ct, 32'h0);
    check(rv, 32'h4f);
    // clock-out start sequence and period
    apb(1'b1, o_ct, 32'h0);
    apb(1'b1, o_md, 32'h2);
    apb(1'b1, o_rl, 32'hfffe);
    apb(1'b1, o_cn, 32'hfffe);
    apb(1'b1, o_ct, 32'h04);
    check(c_oe, 1'b1);
    wt(0, 1'b1, n);
    wt(0, 1'b0, n);
    wt(0, 1'b1, a);
    wt(0, 1'b0, b);
    check(a, 4);
    check(a + b, 8);
    check(c_in, c_out);
    apb(1'b0, o_ct, 32'h0);
    check(rv, 32'h04);
    check(irq_request, 1'b0);
    close_out();
  end
endmodule // updown_reload_clockout_timer_tb
`default_nettype wire
